// >>> pkg/masb_pkg.sv
package masb_pkg;

   // Register bank geometry
   localparam int          MASB_NUM_REGS   = 36;
   localparam logic [5:0]  MASB_NUM_SLOTS  = 6'h24;
   localparam logic [31:0] MASB_RESET_WORD = 32'h00000000;

   // Printed offsets are register indices; byte address is index times four
   localparam logic [12:0] MASB_IDX_TABLE [MASB_NUM_REGS] = '{
      13'h0190, 13'h0196, 13'h0410, 13'h0440, 13'h0442, 13'h0444,
      13'h0468, 13'h0472, 13'h0474, 13'h047A, 13'h047C, 13'h047E,
      13'h04B6, 13'h04B8, 13'h04D2, 13'h04D4, 13'h04D6, 13'h04D8,
      13'h04E2, 13'h04E4, 13'h04E6, 13'h04E8, 13'h0524, 13'h053C,
      13'h054C, 13'h05D2, 13'h0604, 13'h0606, 13'h0680, 13'h068A,
      13'h06BE, 13'h0702, 13'h0748, 13'h074A, 13'h0758, 13'h075C};

   // Slots of the registers with documented layouts or narrow width
   localparam logic [5:0]  MASB_SLOT_STATE      = 6'h00;
   localparam logic [5:0]  MASB_SLOT_FG_SPEED   = 6'h01;
   localparam logic [5:0]  MASB_SLOT_BUS_CURR   = 6'h02;
   localparam logic [5:0]  MASB_SLOT_SENSE_GAIN = 6'h06;
   localparam logic [5:0]  MASB_SLOT_VOLT_GAIN  = 6'h07;
   localparam logic [31:0] MASB_NARROW_MASK     = 32'h0000FFFF;

   // Interrupt registers
   localparam logic [12:0] MASB_IDX_IRQ_STATUS = 13'h07F0;
   localparam logic [12:0] MASB_IDX_IRQ_MASK   = 13'h07F2;
   localparam int          MASB_EV_W           = 3;
   localparam int          MASB_EV_STATE       = 0;
   localparam int          MASB_EV_FAULT       = 1;
   localparam int          MASB_EV_BAD_WRITE   = 2;
   localparam logic [2:0]  MASB_EV_RESET       = 3'h0;

   // AHB-Lite encodings
   localparam logic [1:0]  MASB_HTRANS_NONSEQ  = 2'h2;
   localparam logic        MASB_HRESP_OKAY     = 1'h0;
   localparam logic [16:0] MASB_ADDR_HIGH_ZERO = 17'h00000;

   // Operating state codes
   typedef enum logic [15:0]
   {
      MASB_STATE_IDLE                  = 16'h0000,
      MASB_STATE_INITIAL_SPEED_DETECT  = 16'h0001,
      MASB_STATE_OUTPUTS_HIZ           = 16'h0002,
      MASB_STATE_START_BRAKE           = 16'h0003,
      MASB_STATE_SLOW_FIRST_CYCLE      = 16'h0005,
      MASB_STATE_ALIGN                 = 16'h0006,
      MASB_STATE_OPEN_LOOP             = 16'h0007,
      MASB_STATE_CLOSED_UNALIGNED      = 16'h0008,
      MASB_STATE_CLOSED_ALIGNED        = 16'h0009,
      MASB_STATE_CLOSED_ACTIVE_BRAKE   = 16'h000A,
      MASB_STATE_SOFT_STOP             = 16'h000B,
      MASB_STATE_RECIRCULATION_STOP    = 16'h000C,
      MASB_STATE_STOP_BRAKE            = 16'h000D,
      MASB_STATE_FAULT                 = 16'h000E
   } masb_state_code_t;

   // Snapshot written by the control algorithm
   typedef struct packed
   {
      logic        valid;
      logic [5:0]  slot;
      logic [31:0] data;
   } masb_update_t;

endpackage

// >>> src/masb_bank.sv
`timescale 1ns/1ps
module masb_bank
(
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   input  wire logic                  ce,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic                  hready,
   input  wire logic [31:0]           hwdata,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   input  wire masb_pkg::masb_update_t alg_update,
   output logic                       irq
);

   logic [31:0]                     bank_mem [masb_pkg::MASB_NUM_REGS];
   logic [31:0]                     hrdata_reg;
   logic                            hreadyout_reg;
   logic                            hresp_reg;
   logic                            irq_reg;
   logic                            wr_pend_reg;
   logic [12:0]                     wr_idx_reg;
   logic [masb_pkg::MASB_EV_W-1:0]  status_reg;
   logic [masb_pkg::MASB_EV_W-1:0]  status_next;
   logic [masb_pkg::MASB_EV_W-1:0]  mask_reg;
   logic [masb_pkg::MASB_EV_W-1:0]  events;
   logic [masb_pkg::MASB_EV_W-1:0]  w1c;
   logic                            addr_phase;
   logic [12:0]                     addr_idx;
   logic                            addr_in_range;
   logic [6:0]                      addr_slot;
   logic                            upd_ok;
   logic [15:0]                     upd_code;
   logic [15:0]                     cur_code;

   // Index to slot lookup, shared by read decode and checking
   function automatic logic [6:0] slot_lookup(input logic [12:0] idx);
      logic [6:0] res;
      res = 7'h00;
      for (int i = 0; i < masb_pkg::MASB_NUM_REGS; i++)
      begin
         if (masb_pkg::MASB_IDX_TABLE[i] == idx)
         begin
            res = {1'b1, 6'(i)};
         end
      end
      return res;
   endfunction

   // Narrow registers keep their upper half at zero
   function automatic logic [31:0] fit_width(input logic [5:0] slot, input logic [31:0] d);
      logic [31:0] res;
      res = d;
      if (slot == masb_pkg::MASB_SLOT_STATE || slot == masb_pkg::MASB_SLOT_SENSE_GAIN ||
          slot == masb_pkg::MASB_SLOT_VOLT_GAIN)
      begin
         res = d & masb_pkg::MASB_NARROW_MASK;
      end
      return res;
   endfunction

   // Address phase qualification; only word-aligned low addresses map
   assign addr_phase    = hsel && hready && htrans == masb_pkg::MASB_HTRANS_NONSEQ;
   assign addr_idx      = haddr[14:2];
   assign addr_in_range = haddr[31:15] == masb_pkg::MASB_ADDR_HIGH_ZERO && haddr[1:0] == 2'h0;
   assign addr_slot     = slot_lookup(addr_idx);   // One lookup for read mux and checks

   // Algorithm update decode
   assign upd_ok   = alg_update.valid && alg_update.slot < masb_pkg::MASB_NUM_SLOTS;
   assign upd_code = alg_update.data[15:0];
   assign cur_code = bank_mem[masb_pkg::MASB_SLOT_STATE][15:0];

   // Snapshot storage, written only by the algorithm port
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < masb_pkg::MASB_NUM_REGS; i++)
         begin
            bank_mem[i] <= masb_pkg::MASB_RESET_WORD;
         end
      end
      else if (ce && upd_ok)
      begin
         bank_mem[alg_update.slot] <= fit_width(alg_update.slot, alg_update.data);
      end
   end

   // Read data latched at the address edge, so reads never stall
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         hrdata_reg <= masb_pkg::MASB_RESET_WORD;
      end
      else if (ce && addr_phase && !hwrite)
      begin
         if (!addr_in_range)
         begin
            hrdata_reg <= masb_pkg::MASB_RESET_WORD;
         end
         else if (addr_idx == masb_pkg::MASB_IDX_IRQ_STATUS)
         begin
            hrdata_reg <= {29'h00000000, status_reg};
         end
         else if (addr_idx == masb_pkg::MASB_IDX_IRQ_MASK)
         begin
            hrdata_reg <= {29'h00000000, mask_reg};
         end
         else if (addr_slot[6])
         begin
            hrdata_reg <= bank_mem[addr_slot[5:0]];
         end
         else
         begin
            hrdata_reg <= masb_pkg::MASB_RESET_WORD;   // Reserved reads zero
         end
      end
   end

   // Write address capture; data follows one cycle later
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= 13'h0000;
      end
      else if (ce)
      begin
         wr_pend_reg <= addr_phase && hwrite;
         wr_idx_reg  <= addr_in_range ? addr_idx : 13'h1FFF;
      end
   end

   // Zero wait states, always OKAY
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         hreadyout_reg <= 1'b0;
         hresp_reg     <= masb_pkg::MASB_HRESP_OKAY;
      end
      else
      begin
         hreadyout_reg <= 1'b1;
         hresp_reg     <= masb_pkg::MASB_HRESP_OKAY;
      end
   end

   // Events: state change, fault entry, write to read-only or reserved space
   always_comb
   begin
      events = masb_pkg::MASB_EV_RESET;
      w1c    = masb_pkg::MASB_EV_RESET;
      if (upd_ok && alg_update.slot == masb_pkg::MASB_SLOT_STATE)
      begin
         events[masb_pkg::MASB_EV_STATE] = upd_code != cur_code;
         events[masb_pkg::MASB_EV_FAULT] = upd_code == masb_pkg::MASB_STATE_FAULT &&
                                           cur_code != masb_pkg::MASB_STATE_FAULT;
      end
      if (wr_pend_reg)
      begin
         if (wr_idx_reg == masb_pkg::MASB_IDX_IRQ_STATUS)
         begin
            w1c = hwdata[masb_pkg::MASB_EV_W-1:0];
         end
         else if (wr_idx_reg != masb_pkg::MASB_IDX_IRQ_MASK)
         begin
            events[masb_pkg::MASB_EV_BAD_WRITE] = 1'b1;
         end
      end
      // Set wins over a clear in the same cycle
      status_next = (status_reg & ~w1c) | events;
   end

   // Sticky status and mask
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         status_reg <= masb_pkg::MASB_EV_RESET;
         mask_reg   <= masb_pkg::MASB_EV_RESET;
      end
      else if (ce)
      begin
         status_reg <= status_next;
         if (wr_pend_reg && wr_idx_reg == masb_pkg::MASB_IDX_IRQ_MASK)
         begin
            mask_reg <= hwdata[masb_pkg::MASB_EV_W-1:0];
         end
      end
   end

   // Interrupt level, one cycle behind status for a clean flop output
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         irq_reg <= 1'b0;
      end
      else if (ce)
      begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   assign hrdata    = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp     = hresp_reg;
   assign irq       = irq_reg;

   // Helper: expected read value captured beside the design path
   logic        rd_chk_reg;
   logic        rd_rsv_reg;
   logic [5:0]  rd_slot_reg;
   logic [31:0] rd_val_reg;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rd_chk_reg  <= 1'b0;
         rd_rsv_reg  <= 1'b0;
         rd_slot_reg <= 6'h00;
         rd_val_reg  <= 32'h00000000;
      end
      else
      begin
         rd_chk_reg  <= ce && addr_phase && !hwrite && addr_in_range && addr_slot[6];
         rd_rsv_reg  <= ce && addr_phase && !hwrite &&
                        (!addr_in_range || (!addr_slot[6] &&
                         addr_idx != masb_pkg::MASB_IDX_IRQ_STATUS &&
                         addr_idx != masb_pkg::MASB_IDX_IRQ_MASK));
         rd_slot_reg <= addr_slot[5:0];
         rd_val_reg  <= bank_mem[addr_slot[5:0]];
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_read_returns_word: assert property (rd_chk_reg |-> hrdata == rd_val_reg)
      else $error("read data differs from stored word");

   a_state_code_narrow: assert property (
      rd_chk_reg && rd_slot_reg == masb_pkg::MASB_SLOT_STATE |-> hrdata[31:16] == 16'h0000)
      else $error("state word has upper bits set");

   a_fault_entry_flag: assert property (
      ce && upd_ok && alg_update.slot == masb_pkg::MASB_SLOT_STATE &&
      upd_code == masb_pkg::MASB_STATE_FAULT && cur_code != masb_pkg::MASB_STATE_FAULT
      |=> status_reg[masb_pkg::MASB_EV_FAULT] && cur_code == masb_pkg::MASB_STATE_FAULT)
      else $error("fault entry not flagged");

   a_speed_full_width: assert property (
      ce && upd_ok && alg_update.slot == masb_pkg::MASB_SLOT_FG_SPEED
      |=> bank_mem[masb_pkg::MASB_SLOT_FG_SPEED] == $past(alg_update.data))
      else $error("speed word not stored whole");

   a_reset_state_zero: assert property (
      $fell(srst) |-> bank_mem[masb_pkg::MASB_SLOT_STATE] == 32'h00000000)
      else $error("state not zero after reset");

   a_reset_speed_zero: assert property (
      $fell(srst) |-> bank_mem[masb_pkg::MASB_SLOT_FG_SPEED] == 32'h00000000)
      else $error("speed not zero after reset");

   a_reset_bus_zero: assert property (
      $fell(srst) |-> bank_mem[masb_pkg::MASB_SLOT_BUS_CURR] == 32'h00000000)
      else $error("bus current not zero after reset");

   a_bus_current_full: assert property (
      ce && upd_ok && alg_update.slot == masb_pkg::MASB_SLOT_BUS_CURR
      |=> bank_mem[masb_pkg::MASB_SLOT_BUS_CURR] == $past(alg_update.data))
      else $error("bus current not stored whole");

   a_read_no_effect: assert property (
      addr_phase && !hwrite && !alg_update.valid
      |=> $stable(bank_mem[masb_pkg::MASB_SLOT_STATE]) &&
          $stable(bank_mem[masb_pkg::MASB_SLOT_BUS_CURR]))
      else $error("read disturbed stored words");

   a_bad_write_flag: assert property (
      ce && wr_pend_reg && wr_idx_reg == masb_pkg::MASB_IDX_TABLE[0]
      |=> status_reg[masb_pkg::MASB_EV_BAD_WRITE] ##1 1'b1)
      else $error("write to read-only word not flagged");

   // Bus port, algorithm port, interrupt and freeze checks
   a_ready_no_wait: assert property (
      !srst |=> hreadyout && hresp == masb_pkg::MASB_HRESP_OKAY)
      else $error("slave not ready or response not okay");

   a_irq_follows_mask: assert property (
      ce |=> irq_reg == |($past(status_reg) & $past(mask_reg)))
      else $error("interrupt level does not follow status and mask");

   a_state_code_stored: assert property (
      ce && upd_ok && alg_update.slot == masb_pkg::MASB_SLOT_STATE
      |=> cur_code == $past(upd_code) &&
          bank_mem[masb_pkg::MASB_SLOT_STATE][31:16] == 16'h0000)
      else $error("state code not stored as a 16-bit word");

   a_state_change_flag: assert property (
      ce && upd_ok && alg_update.slot == masb_pkg::MASB_SLOT_STATE && upd_code != cur_code
      |=> status_reg[masb_pkg::MASB_EV_STATE])
      else $error("state change not flagged");

   a_bus_write_ignored: assert property (
      ce && wr_pend_reg && !alg_update.valid
      |=> $stable(bank_mem[masb_pkg::MASB_SLOT_STATE]) &&
          $stable(bank_mem[masb_pkg::MASB_SLOT_FG_SPEED]) &&
          $stable(bank_mem[masb_pkg::MASB_SLOT_BUS_CURR]))
      else $error("bus write changed a read-only word");

   a_bad_write_any: assert property (
      ce && wr_pend_reg && wr_idx_reg != masb_pkg::MASB_IDX_IRQ_STATUS &&
      wr_idx_reg != masb_pkg::MASB_IDX_IRQ_MASK
      |=> status_reg[masb_pkg::MASB_EV_BAD_WRITE])
      else $error("refused write not flagged");

   a_set_beats_clear: assert property (
      ce |=> (status_reg & $past(events)) == $past(events))
      else $error("event lost against a clear");

   a_clear_by_one: assert property (
      ce && wr_pend_reg && wr_idx_reg == masb_pkg::MASB_IDX_IRQ_STATUS
      |=> (status_reg & $past(w1c) & ~$past(events)) == masb_pkg::MASB_EV_RESET)
      else $error("status bit not cleared by a one");

   a_mask_written: assert property (
      ce && wr_pend_reg && wr_idx_reg == masb_pkg::MASB_IDX_IRQ_MASK
      |=> mask_reg == $past(hwdata[masb_pkg::MASB_EV_W-1:0]))
      else $error("mask write lost");

   a_gain_words_narrow: assert property (
      rd_chk_reg && (rd_slot_reg == masb_pkg::MASB_SLOT_SENSE_GAIN ||
                     rd_slot_reg == masb_pkg::MASB_SLOT_VOLT_GAIN)
      |-> hrdata[31:16] == 16'h0000)
      else $error("gain word has upper bits set");

   a_reserved_reads_zero: assert property (
      rd_rsv_reg |-> hrdata == masb_pkg::MASB_RESET_WORD)
      else $error("reserved read not zero");

   a_frozen_when_off: assert property (
      !ce |=> $stable(status_reg) && $stable(mask_reg) && $stable(irq_reg) &&
              $stable(hrdata_reg) && $stable(bank_mem[masb_pkg::MASB_SLOT_FG_SPEED]))
      else $error("state moved while the clock enable was low");

   a_refused_slot: assert property (
      ce && alg_update.valid && alg_update.slot >= masb_pkg::MASB_NUM_SLOTS
      |=> $stable(bank_mem[masb_pkg::MASB_SLOT_STATE]) &&
          $stable(bank_mem[masb_pkg::MASB_SLOT_BUS_CURR]))
      else $error("update to an unmapped slot was stored");

   c_read_state: cover property (rd_chk_reg && rd_slot_reg == masb_pkg::MASB_SLOT_STATE);
   c_fault_entry: cover property ($rose(status_reg[masb_pkg::MASB_EV_FAULT]));
   c_irq_raised: cover property ($rose(irq_reg));
   c_bad_write: cover property ($rose(status_reg[masb_pkg::MASB_EV_BAD_WRITE]));
   c_frozen_update: cover property (!ce && alg_update.valid);

endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic                   sys_clk;
   logic                   srst;
   logic                   ce;
   logic                   hsel;
   logic [31:0]            haddr;
   logic [1:0]             htrans;
   logic                   hwrite;
   logic [2:0]             hsize;
   logic                   hready;
   logic [31:0]            hwdata;
   logic [31:0]            hrdata;
   logic                   hreadyout;
   logic                   hresp;
   masb_pkg::masb_update_t alg_update;
   logic                   irq;
   logic                   chk_r;
   logic                   chk_i;
   logic [31:0]            exp_q[$];
   logic [31:0]            vals[36];
   logic [15:0]            codes[8];
   int                     err_count;
   int                     n_tests;

   // Single slave: its ready is the bus ready
   assign hready = hreadyout;

   masb_bank dut_u
   (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .ce         (ce),
      .hsel       (hsel),
      .haddr      (haddr),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hsize      (hsize),
      .hready     (hready),
      .hwdata     (hwdata),
      .hrdata     (hrdata),
      .hreadyout  (hreadyout),
      .hresp      (hresp),
      .alg_update (alg_update),
      .irq        (irq)
   );

   // Byte address is four times the register index
   function automatic logic [31:0] ad(input logic [12:0] i);
      return {17'h00000, i, 2'h0};
   endfunction

   // Narrow words read back with a zero upper half
   function automatic logic [31:0] nar(input int s, input logic [31:0] d);
      return (s == 0 || s == 6 || s == 7) ? (d & masb_pkg::MASB_NARROW_MASK) : d;
   endfunction

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bounded wait for ready sampled high at a rising edge
   task automatic wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1)
      begin
         err_count++;
         close_out();
      end
   endtask

   // One single word transfer; reads leave their expectation in the queue
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [31:0] e);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= masb_pkg::MASB_HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      if (!w)
      begin
         exp_q.push_back(e);
         chk_r <= 1'b1;
      end
      wait_rdy();
      chk_r <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, $urandom(), e);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h00000000);
   endtask

   // One-cycle algorithm snapshot pulse, then one idle cycle
   task automatic upd(input int s, input logic [31:0] d);
      alg_update <= {1'b1, 6'(s), d};
      @(posedge sys_clk);
      alg_update <= {1'b0, 6'(s), d};
      @(posedge sys_clk);
   endtask

   // Interrupt level is judged one cycle after its cause settles
   task automatic irq_is(input logic e);
      @(posedge sys_clk);
      exp_q.push_back({31'h00000000, e});
      chk_i <= 1'b1;
      @(posedge sys_clk);
      chk_i <= 1'b0;
   endtask

   // Output watcher: oldest note against what appears
   always @(posedge sys_clk)
   begin
      if (chk_i)
         check({31'h00000000, irq}, exp_q.pop_front());
      else if (chk_r && hreadyout === 1'b1)
         check(hrdata, exp_q.pop_front());
   end

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Watchdog against a hung run
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      close_out();
   end

   initial
   begin
      srst = 1'b1;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      alg_update = '0;
      chk_r = 1'b0;
      chk_i = 1'b0;
      err_count = 0;
      n_tests = 0;
      codes = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h000B, 16'h000C, 16'h000D, 16'h000E};
      void'($urandom(32'h3037e9b9));
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      // Every word reads zero out of reset
      for (int i = 0; i < masb_pkg::MASB_NUM_REGS; i++)
         rd(ad(masb_pkg::MASB_IDX_TABLE[i]), 32'h00000000);
      check({31'h00000000, hresp}, {31'h00000000, masb_pkg::MASB_HRESP_OKAY});
      irq_is(1'b0);
      $display("Test reset_values done");
      // Random snapshots into every slot, then read all back
      for (int i = 0; i < masb_pkg::MASB_NUM_REGS; i++)
      begin
         vals[i] = $urandom();
         upd(i, vals[i]);
      end
      for (int i = 0; i < masb_pkg::MASB_NUM_REGS; i++)
         rd(ad(masb_pkg::MASB_IDX_TABLE[i]), nar(i, vals[i]));
      rd(32'h00010000 | ad(masb_pkg::MASB_IDX_TABLE[1]), 32'h00000000);
      rd(ad(masb_pkg::MASB_IDX_TABLE[2]) | 32'h00000002, 32'h00000000);
      $display("Test snapshot_readback done");
      // Eight of the fourteen documented state codes, upper half dropped
      foreach (codes[k])
      begin
         upd(0, {16'hFFFF, codes[k]});
         rd(ad(masb_pkg::MASB_IDX_TABLE[0]), {16'h0000, codes[k]});
      end
      $display("Test state_codes done");
      // Events, mask, write-one-to-clear and refused writes
      wr(ad(masb_pkg::MASB_IDX_IRQ_STATUS), 32'h00000007);
      upd(0, 32'h0000000E);
      rd(ad(masb_pkg::MASB_IDX_IRQ_STATUS), 32'h00000000);
      upd(0, 32'h00000001);
      upd(0, 32'h0000000E);
      rd(ad(masb_pkg::MASB_IDX_IRQ_STATUS), 32'h00000003);
      irq_is(1'b0);
      wr(ad(masb_pkg::MASB_IDX_IRQ_MASK), 32'h00000002);
      irq_is(1'b1);
      rd(ad(masb_pkg::MASB_IDX_IRQ_MASK), 32'h00000002);
      wr(ad(masb_pkg::MASB_IDX_IRQ_STATUS), 32'h00000001);
      rd(ad(masb_pkg::MASB_IDX_IRQ_STATUS), 32'h00000002);
      irq_is(1'b1);
      wr(ad(masb_pkg::MASB_IDX_IRQ_STATUS), 32'h00000002);
      irq_is(1'b0);
      wr(ad(masb_pkg::MASB_IDX_TABLE[2]), $urandom());
      rd(ad(masb_pkg::MASB_IDX_TABLE[2]), vals[2]);
      rd(ad(masb_pkg::MASB_IDX_IRQ_STATUS), 32'h00000004);
      wr(ad(masb_pkg::MASB_IDX_IRQ_MASK), 32'h00000004);
      irq_is(1'b1);
      wr(ad(masb_pkg::MASB_IDX_TABLE[0]), $urandom());
      rd(ad(13'h0004), 32'h00000000);
      wr(ad(masb_pkg::MASB_IDX_IRQ_STATUS), 32'h00000007);
      irq_is(1'b0);
      $display("Test interrupts done");
      // A frozen cycle loses its snapshot, an unmapped slot is ignored
      ce <= 1'b0;
      upd(1, ~vals[1]);
      ce <= 1'b1;
      upd(36 + int'($urandom() % 28), ~vals[2]);
      rd(ad(masb_pkg::MASB_IDX_TABLE[1]), vals[1]);
      rd(ad(masb_pkg::MASB_IDX_TABLE[2]), vals[2]);
      $display("Test clock_enable done");
      // Reset in mid-run clears words, mask and interrupt
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      rd(ad(masb_pkg::MASB_IDX_TABLE[2]), 32'h00000000);
      rd(ad(masb_pkg::MASB_IDX_TABLE[0]), 32'h00000000);
      rd(ad(masb_pkg::MASB_IDX_IRQ_MASK), 32'h00000000);
      irq_is(1'b0);
      $display("Test mid_reset done");
      close_out();
   end
endmodule
